// ### adc_pkg.sv
// Purpose : shared constants and types for the converter control and readout block
// Assumes : byte-wide internal data bus, one state per clk_sys cycle
// Notes   : addresses are the byte addresses seen on the internal bus
package adc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RESULT_BASE = 16'hfee0;
  localparam logic [15:0] ADDR_CTRL_STATUS = 16'hfee8;
  localparam logic [15:0] ADDR_TRIG_CTRL   = 16'hfee9;
  localparam int          RESULT_SEL_LSB   = 1;
  localparam int          RESULT_BASE_LSB  = 3;

  // ----------------------------------------------------------------
  // control/status fields
  // ----------------------------------------------------------------
  localparam int CS_DONE_FLAG   = 7;
  localparam int CS_DONE_IE     = 6;
  localparam int CS_START       = 5;
  localparam int CS_SCAN        = 4;
  localparam int CS_SPEED       = 3;
  localparam int CS_GROUP       = 2;
  localparam int CS_INDEX_HIGH  = 1;
  localparam int CS_INDEX_LOW   = 0;

  // ----------------------------------------------------------------
  // trigger control register
  // ----------------------------------------------------------------
  localparam int         TC_TRIG_EN   = 7;
  localparam logic [7:0] TC_RESET     = 8'h7f;
  localparam logic [6:0] TC_RSVD_ONES = 7'h7f;

  // ----------------------------------------------------------------
  // result layout
  // ----------------------------------------------------------------
  localparam int          RESULT_BITS = 10;
  localparam int          RESULT_PAD  = 6;
  localparam logic [5:0]  RESULT_ZERO = 6'h00;

  // ----------------------------------------------------------------
  // timing, in states; one state is one clk_sys period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int STATE_PERIOD_NS  = 100;
  localparam int SLOW_FIRST_STATE = 274;
  localparam int FAST_FIRST_STATE = 138;
  localparam int SLOW_NEXT_STATE  = 256;
  localparam int FAST_NEXT_STATE  = 128;
  localparam int CNT_W            = 9;
  // longest times: round down
  localparam logic [8:0] SLOW_FIRST_CYC = 9'((SLOW_FIRST_STATE * STATE_PERIOD_NS) / CLK_PERIOD_NS);
  localparam logic [8:0] FAST_FIRST_CYC = 9'((FAST_FIRST_STATE * STATE_PERIOD_NS) / CLK_PERIOD_NS);
  localparam logic [8:0] SLOW_NEXT_CYC  = 9'((SLOW_NEXT_STATE * STATE_PERIOD_NS) / CLK_PERIOD_NS);
  localparam logic [8:0] FAST_NEXT_CYC  = 9'((FAST_NEXT_STATE * STATE_PERIOD_NS) / CLK_PERIOD_NS);
  localparam logic [8:0] CNT_LAST       = 9'h001;

  typedef enum logic [0:0] {
    ADC_IDLE = 1'b0,
    ADC_CONV = 1'b1
  } adc_state_t;

endpackage

// ### adc_result_word.sv
// Purpose : one 16-bit conversion result register, left-justified
// Assumes : load is a one-cycle strobe from the sequencer
// Notes   : read-only to the bus; only the sequencer writes it
module adc_result_word
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        load,
  input  wire logic [9:0]  code,
  output logic      [15:0] word_q
);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      word_q <= 16'h0000;
    end
    else if (load)
    begin
      word_q <= {code, adc_pkg::RESULT_ZERO};
    end
  end

endmodule // adc_result_word

// ### adc_control_readout.sv
// Purpose : control, sequencing and readout of an eight-input converter
// Assumes : analog_code is the front end's result for analog_channel_q
// Notes   : byte bus; a word read returns both result bytes in one access and also loads holding
// Contract
// - scan repeats selected channels until start cleared
// - bit 4 selects single 0, scan 1
// - bit 3 selects slow 274 or fast 138
// - channel field: group bit plus index
// - trigger enable bit 7, resets to 7f
// - reserved bits ignore writes, read one
// - enabled trigger pin falling edge starts conversion
// - result upper direct, lower via holding register
// - upper read copies lower byte to holding
// - lower read returns holding register contents
// - ten-bit result left-justified, low six zero
// - single mode clears start on completion, halts
// - scan result goes to channel's own register
module adc_control_readout
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic        bus_word,
  input  wire logic [7:0]  bus_wdata,
  output logic      [15:0] bus_rdata_q,
  input  wire logic        standby,
  input  wire logic        external_trigger_pin_n,
  input  wire logic [9:0]  analog_code,
  output logic      [2:0]  analog_channel_q,
  output logic             converting_q,
  output logic             done_flag_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adc_pkg::adc_state_t state_q;
  logic        conversion_start_bit_q;
  logic        done_ie_q;
  logic        scan_mode_q;
  logic        conversion_speed_select_q;
  logic        channel_group_select_q;
  logic [1:0]  channel_index_q;
  logic        external_trigger_enable_q;
  logic [8:0]  cnt_q;
  logic [1:0]  cur_q;
  logic [7:0]  hold_q;
  logic        pin_q;
  logic        trig_fire_q;
  logic [3:0]  load_v;
  logic [15:0] result_w [4];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic       hit_result;
  logic       hit_cs;
  logic       hit_tc;
  logic [1:0] res_sel;
  logic       res_lo;
  logic       upper_rd;
  logic       conv_done;
  logic       scan_last;

  assign hit_result = bus_addr[15:adc_pkg::RESULT_BASE_LSB]
                      == adc_pkg::ADDR_RESULT_BASE[15:adc_pkg::RESULT_BASE_LSB];
  assign hit_cs     = bus_addr == adc_pkg::ADDR_CTRL_STATUS;
  assign hit_tc     = bus_addr == adc_pkg::ADDR_TRIG_CTRL;
  assign res_sel    = bus_addr[adc_pkg::RESULT_SEL_LSB +: 2];
  assign res_lo     = bus_addr[0];
  assign upper_rd   = bus_rd && hit_result && !res_lo;
  assign conv_done  = state_q == adc_pkg::ADC_CONV && cnt_q == adc_pkg::CNT_LAST;
  assign scan_last  = cur_q == channel_index_q;

  // ----------------------------------------------------------------
  // external trigger
  // ----------------------------------------------------------------
  // pin is synchronous: edge found on the first edge it reads low, start set on the next
  // a second flop stage here would push the start past two cycles
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_q       <= 1'b1;
      trig_fire_q <= 1'b0;
    end
    else
    begin
      pin_q       <= external_trigger_pin_n;
      trig_fire_q <= external_trigger_enable_q && pin_q && !external_trigger_pin_n;
    end
  end

  // ----------------------------------------------------------------
  // trigger control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      external_trigger_enable_q <= adc_pkg::TC_RESET[adc_pkg::TC_TRIG_EN];
    end
    else if (standby)
    begin
      external_trigger_enable_q <= adc_pkg::TC_RESET[adc_pkg::TC_TRIG_EN];
    end
    else if (bus_wr && hit_tc)
    begin
      external_trigger_enable_q <= bus_wdata[adc_pkg::TC_TRIG_EN];
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  // settings are taken as written; changing them mid-conversion is the caller's hazard
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      done_ie_q                 <= 1'b0;
      scan_mode_q               <= 1'b0;
      conversion_speed_select_q <= 1'b0;
      channel_group_select_q    <= 1'b0;
      channel_index_q           <= 2'b00;
    end
    else if (bus_wr && hit_cs)
    begin
      done_ie_q                 <= bus_wdata[adc_pkg::CS_DONE_IE];
      scan_mode_q               <= bus_wdata[adc_pkg::CS_SCAN];
      conversion_speed_select_q <= bus_wdata[adc_pkg::CS_SPEED];
      channel_group_select_q    <= bus_wdata[adc_pkg::CS_GROUP];
      channel_index_q           <= {bus_wdata[adc_pkg::CS_INDEX_HIGH],
                                    bus_wdata[adc_pkg::CS_INDEX_LOW]};
    end
  end

  // trigger set wins over both software clear and completion clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      conversion_start_bit_q <= 1'b0;
    end
    else if (trig_fire_q)
    begin
      conversion_start_bit_q <= 1'b1;
    end
    else if (bus_wr && hit_cs)
    begin
      conversion_start_bit_q <= bus_wdata[adc_pkg::CS_START];
    end
    else if (conv_done && !scan_mode_q)
    begin
      conversion_start_bit_q <= 1'b0;
    end
  end

  // completion flag: a 0 write clears, a completion in the same cycle wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      done_flag_q <= 1'b0;
    end
    else if (conv_done && (!scan_mode_q || scan_last))
    begin
      done_flag_q <= 1'b1;
    end
    else if (bus_wr && hit_cs && !bus_wdata[adc_pkg::CS_DONE_FLAG])
    begin
      done_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= adc_pkg::ADC_IDLE;
      cnt_q   <= adc_pkg::CNT_LAST;
      cur_q   <= 2'b00;
    end
    else if (!conversion_start_bit_q)
    begin
      state_q <= adc_pkg::ADC_IDLE;
    end
    else
    begin
      case (state_q)
        adc_pkg::ADC_IDLE:
        begin
          state_q <= adc_pkg::ADC_CONV;
          // the start edge is the first state, so the count is loaded one short
          cnt_q   <= conversion_speed_select_q
                     ? adc_pkg::FAST_FIRST_CYC - adc_pkg::CNT_LAST
                     : adc_pkg::SLOW_FIRST_CYC - adc_pkg::CNT_LAST;
          cur_q   <= scan_mode_q ? 2'b00 : channel_index_q;
        end
        adc_pkg::ADC_CONV:
        begin
          if (conv_done)
          begin
            if (!scan_mode_q)
            begin
              state_q <= adc_pkg::ADC_IDLE;
            end
            else
            begin
              cnt_q <= conversion_speed_select_q ? adc_pkg::FAST_NEXT_CYC
                                                 : adc_pkg::SLOW_NEXT_CYC;
              cur_q <= scan_last ? 2'b00 : cur_q + 2'b01;
            end
          end
          else
          begin
            cnt_q <= cnt_q - adc_pkg::CNT_LAST;
          end
        end
        default:
        begin
          state_q <= adc_pkg::ADC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      analog_channel_q <= 3'h0;
      converting_q     <= 1'b0;
    end
    else
    begin
      analog_channel_q <= {channel_group_select_q, cur_q};
      converting_q     <= state_q == adc_pkg::ADC_CONV;
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  // register index is the channel's low two bits in both groups
  always_comb
  begin
    load_v = 4'h0;
    if (conv_done && conversion_start_bit_q)
    begin
      load_v[cur_q] = 1'b1;
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_res
    adc_result_word u_res
    (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .load    (load_v[i]),
      .code    (analog_code),
      .word_q  (result_w[i])
    );
  end

  // ----------------------------------------------------------------
  // readout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      hold_q <= 8'h00;
    end
    else if (upper_rd)
    begin
      hold_q <= result_w[res_sel][7:0];
    end
  end

  // writes to results and holding fall through: nothing decodes them
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_rdata_q <= 16'h0000;
    end
    else if (bus_rd)
    begin
      bus_rdata_q <= 16'h0000;
      if (hit_result && bus_word)
      begin
        bus_rdata_q <= result_w[res_sel];
      end
      else if (hit_result && res_lo)
      begin
        bus_rdata_q[7:0] <= hold_q;
      end
      else if (hit_result)
      begin
        bus_rdata_q[7:0] <= result_w[res_sel][15:8];
      end
      else if (hit_cs)
      begin
        bus_rdata_q[7:0] <= {done_flag_q, done_ie_q, conversion_start_bit_q, scan_mode_q,
                             conversion_speed_select_q, channel_group_select_q,
                             channel_index_q};
      end
      else if (hit_tc)
      begin
        bus_rdata_q[7:0] <= {external_trigger_enable_q, adc_pkg::TC_RSVD_ONES};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_trig_fall;
    external_trigger_enable_q && !conversion_start_bit_q && $fell(external_trigger_pin_n);
  endsequence

  a_trig_sets_start: assert property (
    s_trig_fall |-> ##[1:2] conversion_start_bit_q)
    else $error("trigger edge did not set start in time");

  a_trig_ignored: assert property (
    !external_trigger_enable_q && !conversion_start_bit_q && !bus_wr && !standby
    && $fell(external_trigger_pin_n) ##1 !bus_wr ##1 !bus_wr
    |-> !conversion_start_bit_q)
    else $error("disabled trigger started a conversion");

  a_single_stops: assert property (
    conv_done && !scan_mode_q && !trig_fire_q && !bus_wr
    |=> !conversion_start_bit_q ##1 state_q == adc_pkg::ADC_IDLE)
    else $error("single conversion did not stop");

  a_scan_runs_on: assert property (
    conv_done && scan_mode_q && !bus_wr
    |=> conversion_start_bit_q && state_q == adc_pkg::ADC_CONV)
    else $error("scan stopped by itself");

  a_scan_wraps: assert property (
    conv_done && scan_mode_q && scan_last && !bus_wr |=> cur_q == 2'b00)
    else $error("scan did not wrap to group base");

  a_result_store: assert property (
    conv_done && conversion_start_bit_q
    |=> result_w[$past(cur_q)] == {$past(analog_code), adc_pkg::RESULT_ZERO})
    else $error("result not stored in its channel register");

  a_hold_load: assert property (
    upper_rd && !load_v[res_sel] |=> hold_q == result_w[$past(res_sel)][7:0])
    else $error("upper read did not fill holding register");

  a_low_read: assert property (
    bus_rd && hit_result && res_lo && !bus_word |=> bus_rdata_q == {8'h00, $past(hold_q)})
    else $error("lower read did not return holding register");

  a_hold_keeps: assert property (
    !upper_rd |=> $stable(hold_q))
    else $error("holding register changed without upper read");

  a_trig_ctrl_ones: assert property (
    bus_rd && hit_tc |=> bus_rdata_q[6:0] == adc_pkg::TC_RSVD_ONES)
    else $error("reserved trigger control bits not read as one");

  a_standby_clear: assert property (
    standby |=> !external_trigger_enable_q)
    else $error("standby did not clear trigger enable");

  a_first_time: assert property (
    state_q == adc_pkg::ADC_IDLE && conversion_start_bit_q && conversion_speed_select_q
    |=> cnt_q == adc_pkg::FAST_FIRST_CYC - adc_pkg::CNT_LAST)
    else $error("fast first conversion time wrong");

endmodule // adc_control_readout

// ### adc_bus_host.sv
// Purpose : byte bus master standing in for the processor and transfer controller
// Assumes : one strobe cycle per access, read data valid one cycle after the read edge
// Notes   : released address and data lines show the inverse of the last value
module adc_bus_host
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] bus_rdata_q,
  output logic      [15:0] bus_addr,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic             bus_word,
  output logic      [7:0]  bus_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    bus_addr  = 16'h0000;
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_word  = 1'b0;
    bus_wdata = 8'h00;
  end

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // callers only touch mode, speed and channel while stopped
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask

  // full results come from a word read or upper-first byte reads
  // an upper-only read is legal for eight-bit use
  task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_word <= w;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
    bus_word <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata_q;
  endtask
endmodule // adc_bus_host

// ### adc_control_readout_test.sv
// Purpose : self-checking bench for the converter control and readout block
// Assumes : front end code is built from the channel so each register differs
// Notes   : expected words are worked out here, never read back from the design
module adc_control_readout_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys;
  logic        rstn;
  logic        standby;
  logic        external_trigger_pin_n;
  logic [15:0] bus_addr;
  logic        bus_rd;
  logic        bus_wr;
  logic        bus_word;
  logic [7:0]  bus_wdata;
  logic [15:0] bus_rdata_q;
  logic [2:0]  analog_channel_q;
  logic        converting_q;
  logic        done_flag_q;
  logic [9:0]  analog_code;
  int          n_mismatch;
  int          comparisons;

  // low two code bits follow the channel, so lower bytes tell registers apart
  assign analog_code = {analog_channel_q, 4'h5, analog_channel_q};

  adc_control_readout adc_control_readout_inst
  (
    .clk_sys                (clk_sys),
    .rstn                   (rstn),
    .bus_addr               (bus_addr),
    .bus_rd                 (bus_rd),
    .bus_wr                 (bus_wr),
    .bus_word               (bus_word),
    .bus_wdata              (bus_wdata),
    .bus_rdata_q            (bus_rdata_q),
    .standby                (standby),
    .external_trigger_pin_n (external_trigger_pin_n),
    .analog_code            (analog_code),
    .analog_channel_q       (analog_channel_q),
    .converting_q           (converting_q),
    .done_flag_q            (done_flag_q)
  );

  adc_bus_host adc_bus_host_inst
  (
    .clk_sys     (clk_sys),
    .bus_rdata_q (bus_rdata_q),
    .bus_addr    (bus_addr),
    .bus_rd      (bus_rd),
    .bus_wr      (bus_wr),
    .bus_word    (bus_word),
    .bus_wdata   (bus_wdata)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] exp_word(input logic [2:0] ch);
    return {ch, 4'h5, ch, 6'h00};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a, input logic w,
                        input logic [15:0] exp);
    logic [15:0] d;
    adc_bus_host_inst.rd(a, w, d);
    chk(name, d, exp);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // counts edges until the completion flag shows; a hang ends the run
  task automatic wait_done(output int n);
    n = 0;
    while (n < 400)
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (done_flag_q === 1'b1)
        return;
    end
    n_mismatch++;
    $display("wrong value done_wait expected done seen timeout");
    complete_run();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_chk("trig_ctrl_reset", 16'hfee9, 1'b0, 16'h007f);
    rd_chk("ctrl_reset", 16'hfee8, 1'b0, 16'h0000);
    rd_chk("unmapped", 16'hfe00, 1'b0, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_single();
    int n;
    adc_bus_host_inst.wr(16'hfee8, 8'h27);
    wait_done(n);
    chk("single_slow_time", 16'(n), 16'd274);
    rd_chk("single_stopped", 16'hfee8, 1'b0, 16'h0087);
    rd_chk("result_d_word", 16'hfee6, 1'b1, exp_word(3'h7));
    $display("test single done");
  endtask

  task automatic t_scan();
    int n;
    logic [15:0] a0;
    logic [15:0] b1;
    a0 = exp_word(3'h0);
    b1 = exp_word(3'h1);
    adc_bus_host_inst.wr(16'hfee8, 8'h39);
    wait_done(n);
    adc_bus_host_inst.wr(16'hfee8, 8'h39);
    wait_done(n);
    rd_chk("scan_repeats", 16'hfee8, 1'b0, 16'h00b9);
    chk("scan_converting", {15'h0000, converting_q}, 16'h0001);
    adc_bus_host_inst.wr(16'hfee8, 8'h19);
    rd_chk("scan_stopped", 16'hfee8, 1'b0, 16'h0019);
    chk("scan_halted", {15'h0000, converting_q}, 16'h0000);
    rd_chk("result_b_hi", 16'hfee2, 1'b0, {8'h00, b1[15:8]});
    rd_chk("result_a_hi", 16'hfee0, 1'b0, {8'h00, a0[15:8]});
    rd_chk("holding_shared", 16'hfee3, 1'b0, {8'h00, a0[7:0]});
    adc_bus_host_inst.wr(16'hfee1, 8'h55);
    adc_bus_host_inst.wr(16'hfee2, 8'h55);
    rd_chk("holding_kept", 16'hfee1, 1'b0, {8'h00, a0[7:0]});
    rd_chk("result_b_word", 16'hfee2, 1'b1, b1);
    rd_chk("holding_loaded", 16'hfee1, 1'b0, {8'h00, b1[7:0]});
    $display("test scan done");
  endtask

  task automatic t_trigger();
    int n;
    adc_bus_host_inst.wr(16'hfee9, 8'h80);
    rd_chk("trig_enabled", 16'hfee9, 1'b0, 16'h00ff);
    adc_bus_host_inst.wr(16'hfee8, 8'h0e);
    @(posedge clk_sys);
    external_trigger_pin_n <= 1'b0;
    wait_done(n);
    chk("trig_fast_time", 16'(n), 16'd140);
    @(posedge clk_sys);
    external_trigger_pin_n <= 1'b1;
    rd_chk("result_c_word", 16'hfee4, 1'b1, exp_word(3'h6));
    chk("trig_channel", {13'h0000, analog_channel_q}, 16'h0006);
    adc_bus_host_inst.wr(16'hfee9, 8'h00);
    rd_chk("trig_rsvd_ones", 16'hfee9, 1'b0, 16'h007f);
    adc_bus_host_inst.wr(16'hfee8, 8'h0e);
    @(posedge clk_sys);
    external_trigger_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    external_trigger_pin_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd_chk("trig_ignored", 16'hfee8, 1'b0, 16'h000e);
    adc_bus_host_inst.wr(16'hfee9, 8'h80);
    @(posedge clk_sys);
    standby <= 1'b1;
    @(posedge clk_sys);
    standby <= 1'b0;
    rd_chk("trig_standby", 16'hfee9, 1'b0, 16'h007f);
    $display("test trigger done");
  endtask

  initial
  begin
    n_mismatch             = 0;
    comparisons            = 0;
    rstn                   = 1'b0;
    standby                = 1'b0;
    external_trigger_pin_n = 1'b1;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_single();
    t_scan();
    t_trigger();
    complete_run();
  end
endmodule // adc_control_readout_test
